//--- design/tvi_pkg.sv
// package for the timer and vectored interrupt block: register offsets, fields, reset values
// assumes an 8-bit register port and one 100 MHz system clock
// Overview of operation
// - two 8-bit counters, own 6-bit prescalers
// - second prescaler internal or external; first internal
// - prescalers divide by 1 to 64
// - counters count down from 1 to 256
// - end of count raises requests four, five
// - single-pass halts; continuous mode reloads
// - start, stop, resume or reload each counter
// - counter reads are harmless; prescalers unreadable
// - second timer: clock/4 or external input
// - input pin: clock, triggers or gate
// - output pin: first, second or clock
// - first timer may clock the second
// - prescaler setup bit 1 low enables pin
// - six maskable prioritised request sources
// - mask has global and per-request enables
// - requests zero to two from pins, vectors
// - requests three to five, their vectors
// - priority register picks one pending request
// - grant disables interrupts, saves, then vectors
// - routine address is two vector bytes
// - lowest twelve bytes hold six vectors
// - masked requests still latch for polling
// - request bits 7:6 pick pin edges
package tvi_pkg;
	localparam logic [7:0] OFS_TIMER_LINK  = 8'hF0;
	localparam logic [7:0] OFS_TIMER_MODE  = 8'hF1;
	localparam logic [7:0] OFS_SECOND_CNT  = 8'hF2;
	localparam logic [7:0] OFS_SECOND_PRE  = 8'hF3;
	localparam logic [7:0] OFS_FIRST_CNT   = 8'hF4;
	localparam logic [7:0] OFS_FIRST_PRE   = 8'hF5;
	localparam logic [7:0] OFS_PRIORITY    = 8'hF9;
	localparam logic [7:0] OFS_REQUEST     = 8'hFA;
	localparam logic [7:0] OFS_MASK        = 8'hFB;
	// timer mode fields
	localparam int TM_LOAD0    = 0;
	localparam int TM_RUN0     = 1;
	localparam int TM_LOAD1    = 2;
	localparam int TM_RUN1     = 3;
	localparam int TM_PIN_LSB  = 4;
	localparam int TM_OUT_LSB  = 6;
	// prescaler setup fields
	localparam int PRE_CONT    = 0;
	localparam int PRE_INTCLK  = 1;
	localparam int PRE_DIV_LSB = 2;
	localparam int MASK_GLOBAL = 7;
	localparam int NUM_REQ     = 6;
	// input pin modes
	localparam logic [1:0] PIN_CLOCK   = 2'h0;
	localparam logic [1:0] PIN_GATE    = 2'h1;
	localparam logic [1:0] PIN_TRIG    = 2'h2;
	localparam logic [1:0] PIN_RETRIG  = 2'h3;
	// output pin selects
	localparam logic [1:0] OUT_FIRST   = 2'h0;
	localparam logic [1:0] OUT_SECOND  = 2'h1;
	localparam logic [1:0] OUT_CLOCK   = 2'h2;
	// reset values
	localparam logic [7:0] RST_MODE    = 8'h00;
	localparam logic [7:0] RST_PRE     = 8'h02;
	localparam logic [7:0] RST_LOAD    = 8'h00;
	localparam logic [5:0] RST_REQ     = 6'h00;
	// internal clock divided by four for timing
	localparam logic [1:0] INT_DIV_LAST = 2'h3;
	typedef enum logic [1:0] {TVI_IDLE, TVI_FETCH_HI, TVI_FETCH_LO, TVI_DONE} tvi_vec_state_t;
endpackage : tvi_pkg

//--- design/tvi_top.sv
// timers, prescalers and vectored interrupt unit in one module
// assumes synchronous pin inputs and a core that reads vector bytes one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module tvi_top
	import tvi_pkg::*;
(
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	// pins and serial source
	input  wire logic        port3_line1_i,
	input  wire logic        port3_line2_i,
	input  wire logic        port3_line3_i,
	input  wire logic        serial_rx_byte_i,
	output logic             timer_output_pin_o,
	// core side
	input  wire logic        core_take_i,
	output logic             int_pending_o,
	output logic             int_save_o,
	output logic             pm_rd_o,
	output logic      [7:0]  pm_addr_o,
	input  wire logic [7:0]  pm_data_i,
	output logic             isr_valid_o,
	output logic      [15:0] isr_addr_o
);
	logic       rst_meta_q;
	logic       rst_n;
	logic [1:0] div_q;
	logic       int_tick;
	logic [7:0] mode_q;
	logic       link_q;
	logic [7:0] pre_q [2];
	logic [7:0] load_q [2];
	logic [7:0] cnt_q [2];
	logic [5:0] pcnt_q [2];
	logic [1:0] run_q;
	logic [1:0] eoc;
	logic [1:0] src_tick;
	logic [1:0] timer_output_pin_q;
	logic       tin_q;
	logic       p32_q;
	logic       p33_q;
	logic       tin_rise;
	logic       tin_fall;
	logic       p32_rise;
	logic       p32_fall;
	logic       p33_fall;
	logic [1:0] pin_mode;
	logic [1:0] out_sel;
	logic       pin_used;
	logic       trig_start;
	logic [7:0] req_q;
	logic [7:0] mask_q;
	logic [2:0] prio_q;
	logic [5:0] hw_set;
	logic [5:0] eligible;
	logic       found;
	logic [2:0] winner;
	logic [2:0] idx;
	logic [2:0] grant_q;
	logic       grant;
	logic [7:0] vec_hi_q;
	logic       wr_mode;
	tvi_vec_state_t state_q;

	// reset released through two flops
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// internal clock divided by four
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	assign int_tick = (div_q == INT_DIV_LAST);

	// pin history for edge detection
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tin_q <= 1'b0;
			p32_q <= 1'b0;
			p33_q <= 1'b0;
		end else begin
			tin_q <= port3_line1_i;
			p32_q <= port3_line2_i;
			p33_q <= port3_line3_i;
		end
	end
	assign tin_rise = port3_line1_i & ~tin_q;
	assign tin_fall = ~port3_line1_i & tin_q;
	// edges of the two request pins
	assign p32_rise = port3_line2_i & ~p32_q;
	assign p32_fall = ~port3_line2_i & p32_q;
	assign p33_fall = ~port3_line3_i & p33_q;

	assign wr_mode  = reg_wr_i && (reg_addr_i == OFS_TIMER_MODE);
	assign pin_mode = mode_q[TM_PIN_LSB +: 2];
	assign pin_used = ~pre_q[1][PRE_INTCLK];
	assign trig_start = pin_used && tin_rise
		&& ((pin_mode == PIN_RETRIG) || (pin_mode == PIN_TRIG && !run_q[1]));

	// clock source of each prescaler
	always_comb begin
		src_tick[0] = int_tick;
		if (link_q) begin
			src_tick[1] = eoc[0];
		end else if (!pin_used) begin
			src_tick[1] = int_tick;
		end else begin
			case (pin_mode)
				PIN_CLOCK: src_tick[1] = tin_rise;
				PIN_GATE:  src_tick[1] = int_tick & port3_line1_i;
				default:   src_tick[1] = int_tick;
			endcase
		end
	end

	// control registers
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= RST_MODE;
			link_q <= 1'b0;
			prio_q <= 3'h0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_TIMER_MODE: mode_q <= reg_wdata_i;
				OFS_TIMER_LINK: link_q <= reg_wdata_i[0];
				OFS_PRIORITY:   prio_q <= reg_wdata_i[2:0];
				default: ;
			endcase
		end
	end

	// two timers, each a prescaler and a down counter
	for (genvar t = 0; t < 2; t++) begin : g_timer
		logic       tick;
		logic       load_now;
		logic       run_wr;
		logic [7:0] ofs_cnt;
		logic [7:0] ofs_pre;
		logic [5:0] div_field;
		logic       pre_wrap;
		assign ofs_cnt  = (t == 0) ? OFS_FIRST_CNT : OFS_SECOND_CNT;
		assign ofs_pre  = (t == 0) ? OFS_FIRST_PRE : OFS_SECOND_PRE;
		assign load_now = (wr_mode && reg_wdata_i[TM_LOAD0 + 2 * t])
			|| ((t == 1) && trig_start);
		assign run_wr   = reg_wdata_i[TM_RUN0 + 2 * t];
		// prescaler wraps on its last count
		assign div_field = pre_q[t][PRE_DIV_LSB +: 6];
		assign pre_wrap  = run_q[t] && src_tick[t] && (pcnt_q[t] == 6'h01);
		assign tick      = pre_wrap;
		assign eoc[t]    = tick && (cnt_q[t] == 8'h01);

		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) begin
				pre_q[t]  <= RST_PRE;
				load_q[t] <= RST_LOAD;
			end else if (reg_wr_i && reg_addr_i == ofs_pre) begin
				pre_q[t] <= reg_wdata_i;
			end else if (reg_wr_i && reg_addr_i == ofs_cnt) begin
				load_q[t] <= reg_wdata_i;
			end
		end

		// a zero divisor field stands for 64
		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) begin
				pcnt_q[t] <= 6'h00;
			end else if (load_now || pre_wrap) begin
				pcnt_q[t] <= div_field;
			end else if (run_q[t] && src_tick[t]) begin
				pcnt_q[t] <= pcnt_q[t] - 6'h01;
			end
		end

		// a zero load value stands for 256
		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q[t] <= 8'h00;
				run_q[t] <= 1'b0;
				timer_output_pin_q[t] <= 1'b0;
			end else begin
				if (load_now) begin
					cnt_q[t] <= load_q[t];
				end else if (eoc[t]) begin
					cnt_q[t] <= pre_q[t][PRE_CONT] ? load_q[t] : 8'h00;
				end else if (tick) begin
					cnt_q[t] <= cnt_q[t] - 8'h01;
				end
				if (wr_mode) begin
					run_q[t] <= run_wr || ((t == 1) && trig_start);
				end else if ((t == 1) && trig_start) begin
					run_q[t] <= 1'b1;
				end else if (eoc[t] && !pre_q[t][PRE_CONT]) begin
					run_q[t] <= 1'b0;
				end
				if (eoc[t]) begin
					timer_output_pin_q[t] <= ~timer_output_pin_q[t];
				end
			end
		end
	end

	// timer output pin
	assign out_sel = mode_q[TM_OUT_LSB +: 2];

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			timer_output_pin_o <= 1'b0;
		end else begin
			case (out_sel)
				OUT_FIRST:  timer_output_pin_o <= timer_output_pin_q[0];
				OUT_SECOND: timer_output_pin_o <= timer_output_pin_q[1];
				OUT_CLOCK:  timer_output_pin_o <= div_q[1];
				default:    timer_output_pin_o <= 1'b0;
			endcase
		end
	end

	// hardware request sources with selectable edges
	always_comb begin
		logic both;
		both = req_q[7] & req_q[6];
		hw_set[0] = (p32_rise & (req_q[6] | both))
			| (p32_fall & (~req_q[6] | both));
		hw_set[1] = p33_fall;
		hw_set[2] = (tin_rise & (req_q[7] | both)) | (tin_fall & (~req_q[7] | both));
		hw_set[3] = serial_rx_byte_i;
		hw_set[4] = eoc[0];
		hw_set[5] = eoc[1];
	end

	// request register: hardware set wins over a software clear
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= {2'h0, RST_REQ};
		end else begin
			logic [5:0] bits;
			bits = req_q[5:0];
			if (reg_wr_i && reg_addr_i == OFS_REQUEST) begin
				bits = reg_wdata_i[5:0];
				req_q[7:6] <= reg_wdata_i[7:6];
			end
			// clear the request being served itself: a registered index
			// would lag a mask or request write in the cycle before the grant
			if (grant) begin
				bits[winner] = 1'b0;
			end
			req_q[5:0] <= bits | hw_set;
		end
	end

	// mask register; a grant drops the global enable
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= 8'h00;
		end else if (grant) begin
			mask_q[MASK_GLOBAL] <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == OFS_MASK) begin
			mask_q <= reg_wdata_i;
		end
	end

	assign eligible = req_q[5:0] & mask_q[5:0] & {NUM_REQ{mask_q[MASK_GLOBAL]}};

	// rotating priority starting at the programmed request
	always_comb begin
		found  = 1'b0;
		winner = 3'h0;
		idx    = 3'h0;
		for (int k = 0; k < NUM_REQ; k++) begin
			idx = 3'((int'(prio_q) + k) % NUM_REQ);
			if (!found && eligible[idx]) begin
				found  = 1'b1;
				winner = idx;
			end
		end
	end

	assign int_pending_o = found && (state_q == TVI_IDLE);
	assign grant = int_pending_o && core_take_i;

	// vector index latched at the grant, used for the low byte fetch
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			grant_q <= 3'h0;
		end else if (grant) begin
			grant_q <= winner;
		end
	end

	// interrupt cycle: save and fetch the first vector byte, then fetch the second
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= TVI_IDLE;
			int_save_o  <= 1'b0;
			pm_rd_o     <= 1'b0;
			pm_addr_o   <= 8'h00;
			vec_hi_q    <= 8'h00;
			isr_valid_o <= 1'b0;
			isr_addr_o  <= 16'h0000;
		end else begin
			int_save_o  <= 1'b0;
			pm_rd_o     <= 1'b0;
			isr_valid_o <= 1'b0;
			case (state_q)
				TVI_IDLE: begin
					if (grant) begin
						int_save_o <= 1'b1;
						pm_rd_o    <= 1'b1;
						pm_addr_o  <= {4'h0, winner, 1'b0};
						state_q    <= TVI_FETCH_HI;
					end
				end
				TVI_FETCH_HI: begin
					pm_rd_o   <= 1'b1;
					pm_addr_o <= {4'h0, grant_q, 1'b1};
					state_q   <= TVI_FETCH_LO;
				end
				TVI_FETCH_LO: begin
					vec_hi_q <= pm_data_i;
					state_q  <= TVI_DONE;
				end
				TVI_DONE: begin
					isr_addr_o  <= {vec_hi_q, pm_data_i};
					isr_valid_o <= 1'b1;
					state_q     <= TVI_IDLE;
				end
				default: state_q <= TVI_IDLE;
			endcase
		end
	end

	// read data one cycle after the strobe; prescaler setups are write-only
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_TIMER_LINK: reg_rdata_o <= {7'h00, link_q};
				OFS_TIMER_MODE: reg_rdata_o <= {mode_q[7:4], run_q[1], 1'b0, run_q[0], 1'b0};
				OFS_SECOND_CNT: reg_rdata_o <= cnt_q[1];
				OFS_FIRST_CNT:  reg_rdata_o <= cnt_q[0];
				OFS_PRIORITY:   reg_rdata_o <= {5'h00, prio_q};
				OFS_REQUEST:    reg_rdata_o <= req_q;
				OFS_MASK:       reg_rdata_o <= mask_q;
				default:        reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end
endmodule : tvi_top
`default_nettype wire

//--- verif/testbench.sv
// testbench: register calls for timers, request latching and vectored grants
// assumes the core model answers vector fetches from its table
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tvi_pkg::*;
	logic        clock_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic        line1 = 1'b1, line2 = 1'b0, line3 = 1'b1, serial_rx = 1'b0, take_en = 1'b0;
	logic        core_take, int_pending_o, int_save_o, pm_rd_o, isr_valid_o, timer_output_pin, seen_timer_output_pin;
	logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, pm_addr_o, pm_data;
	logic [15:0] isr_addr_o;
	int          error_cnt = 0, checked = 0, n;

	always #5 clock_i = ~clock_i;

	tvi_top dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .port3_line1_i(line1), .port3_line2_i(line2),
		.port3_line3_i(line3), .serial_rx_byte_i(serial_rx), .timer_output_pin_o(timer_output_pin),
		.core_take_i(core_take), .int_pending_o(int_pending_o), .int_save_o(int_save_o),
		.pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o), .pm_data_i(pm_data),
		.isr_valid_o(isr_valid_o), .isr_addr_o(isr_addr_o));
	tvi_core_mdl u_core (.clock_i(clock_i), .take_en_i(take_en), .pm_rd_i(pm_rd_o),
		.pm_addr_i(pm_addr_o), .core_take_o(core_take), .pm_data_o(pm_data));

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		@(posedge clock_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 check(reg_rdata_o, exp);
		@(posedge clock_i);
	endtask : rd
	task automatic wait_isr(input logic [15:0] exp);
		int i;
		i = 0;
		while (isr_valid_o !== 1'b1 && i < 40) begin
			@(posedge clock_i);
			#1 i++;
		end
		check({isr_valid_o, isr_addr_o}, {1'b1, exp});
		@(posedge clock_i);
	endtask : wait_isr
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#100us;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rd(OFS_TIMER_MODE, 8'h00);
		rd(OFS_SECOND_PRE, 8'h00);
		rd(8'h10, 8'h00);
		rd(OFS_MASK, 8'h00);
		// first timer single pass, divide by 2, load 5: ends 37 to 40 clocks after start
		wr(OFS_FIRST_PRE, 8'h08);
		wr(OFS_FIRST_CNT, 8'h05);
		wr(OFS_TIMER_MODE, 8'h03);
		repeat (24) @(posedge clock_i);
		rd(OFS_REQUEST, 8'h00);
		repeat (16) @(posedge clock_i);
		rd(OFS_REQUEST, 8'h10);
		rd(OFS_FIRST_CNT, 8'h00);
		rd(OFS_TIMER_MODE, 8'h00);
		check(int_pending_o, 1'b0);
		// second timer continuous on internal clock over four
		wr(OFS_SECOND_PRE, 8'h07);
		wr(OFS_SECOND_CNT, 8'h02);
		wr(OFS_TIMER_MODE, 8'h0C);
		repeat (40) @(posedge clock_i);
		rd(OFS_TIMER_MODE, 8'h08);
		rd(OFS_REQUEST, 8'h30);
		wr(OFS_TIMER_MODE, 8'h00);
		wr(OFS_REQUEST, 8'h00);
		rd(OFS_REQUEST, 8'h00);
		wr(OFS_REQUEST, 8'h10);
		wr(OFS_MASK, 8'h10);
		check(int_pending_o, 1'b0);
		take_en <= 1'b1;
		for (n = 0; n < NUM_REQ; n++) begin
			wr(OFS_REQUEST, 8'h01 << n);
			wr(OFS_MASK, 8'h80 | (8'h01 << n));
			wait_isr({8'h40 + 8'(2 * n), 8'h41 + 8'(2 * n)});
			rd(OFS_REQUEST, 8'h00);
			rd(OFS_MASK, 8'h01 << n);
		end
		// rotation starting at request four wins over request one
		wr(OFS_PRIORITY, 8'h04);
		wr(OFS_REQUEST, 8'h12);
		wr(OFS_MASK, 8'h92);
		wait_isr(16'h4849);
		rd(OFS_REQUEST, 8'h02);
		// pins: line2 on rising edges, line1 and line3 falling
		wr(OFS_REQUEST, 8'h40);
		line1 <= 1'b0;
		line2 <= 1'b1;
		line3 <= 1'b0;
		repeat (4) @(posedge clock_i);
		rd(OFS_REQUEST, 8'h47);
		wr(OFS_REQUEST, 8'h40);
		line2 <= 1'b0;
		repeat (4) @(posedge clock_i);
		rd(OFS_REQUEST, 8'h40);
		serial_rx <= 1'b1;
		@(posedge clock_i);
		serial_rx <= 1'b0;
		repeat (3) @(posedge clock_i);
		rd(OFS_REQUEST, 8'h48);
		// output pin: first timer toggled once, then clock over four, then low
		check(timer_output_pin, 1'b1);
		wr(OFS_TIMER_MODE, 8'h80);
		@(posedge clock_i);
		#1 seen_timer_output_pin = timer_output_pin;
		repeat (2) @(posedge clock_i);
		#1 check(timer_output_pin, !seen_timer_output_pin);
		@(posedge clock_i);
		wr(OFS_TIMER_MODE, 8'hC0);
		@(posedge clock_i);
		#1 check(timer_output_pin, 1'b0);
		@(posedge clock_i);
		// cascade: second timer counts ends of the first (every 16 clocks)
		wr(OFS_FIRST_PRE, 8'h11);
		wr(OFS_FIRST_CNT, 8'h01);
		wr(OFS_SECOND_PRE, 8'h06);
		wr(OFS_SECOND_CNT, 8'h03);
		wr(OFS_TIMER_LINK, 8'h01);
		wr(OFS_TIMER_MODE, 8'h0F);
		repeat (20) @(posedge clock_i);
		rd(OFS_SECOND_CNT, 8'h02);
		repeat (40) @(posedge clock_i);
		rd(OFS_SECOND_CNT, 8'h00);
		rd(OFS_TIMER_MODE, 8'h02);
		wr(OFS_TIMER_MODE, 8'h00);
		wr(OFS_TIMER_LINK, 8'h00);
		// trigger on the timer input pin starts the second timer
		wr(OFS_SECOND_PRE, 8'h04);
		wr(OFS_TIMER_MODE, 8'h20);
		line1 <= 1'b1;
		@(posedge clock_i);
		rd(OFS_TIMER_MODE, 8'h28);
		repeat (20) @(posedge clock_i);
		rd(OFS_SECOND_CNT, 8'h00);
		rd(OFS_TIMER_MODE, 8'h20);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire

//--- verif/tvi_chk.sv
// checker for register read timing and the vector cycle
// assumes it is bound to tvi_top and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module tvi_chk
	import tvi_pkg::*;
(
	// clock, reset, register port
	input wire logic        clock_i,
	input wire logic        reset_n_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	// core side
	input wire logic        core_take_i,
	input wire logic        int_pending_o,
	input wire logic        int_save_o,
	input wire logic        pm_rd_o,
	input wire logic [7:0]  pm_addr_o,
	input wire logic [7:0]  pm_data_i,
	input wire logic        isr_valid_o,
	input wire logic [15:0] isr_addr_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_prescale_hidden: assert property (reg_rd_i && reg_addr_i == OFS_SECOND_PRE |=>
		reg_rdata_o == 8'h00)
		else $error("prescaler setup readable");
	a_grant_save: assert property (int_pending_o && core_take_i |=> int_save_o && pm_rd_o)
		else $error("grant without save and fetch");
	a_vector_low: assert property (int_save_o |-> !pm_addr_o[0] && pm_addr_o < 8'h0C)
		else $error("vector address outside table");
	a_second_byte: assert property (int_save_o |=> pm_rd_o && pm_addr_o == $past(pm_addr_o) + 8'h01)
		else $error("second vector byte not fetched");
	a_vector_time: assert property (int_save_o |-> ##3 isr_valid_o)
		else $error("routine address late");
	a_isr_bytes: assert property (isr_valid_o |->
		isr_addr_o == {$past(pm_data_i, 2), $past(pm_data_i)})
		else $error("routine address not built from vector bytes");
	a_no_nesting: assert property (int_save_o |-> !int_pending_o [*4])
		else $error("interrupt offered during interrupt cycle");
	a_isr_hold: assert property (!isr_valid_o |-> $stable(isr_addr_o))
		else $error("routine address moved");
	c_grant: cover property (int_save_o);
	c_vector: cover property (isr_valid_o);
	c_read: cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
endmodule : tvi_chk
bind tvi_top tvi_chk u_chk (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .core_take_i(core_take_i),
	.int_pending_o(int_pending_o), .int_save_o(int_save_o), .pm_rd_o(pm_rd_o),
	.pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .isr_valid_o(isr_valid_o),
	.isr_addr_o(isr_addr_o)
);
`default_nettype wire

//--- verif/tvi_core_mdl.sv
// core and program memory model: answers vector fetches, offers interrupt acceptance
// assumes pm_rd_i pulses come from the timer block one cycle before data are wanted
`timescale 1ns/1ps
`default_nettype none
module tvi_core_mdl (
	// clock and control
	input  wire logic       clock_i,
	input  wire logic       take_en_i,
	// memory side
	input  wire logic       pm_rd_i,
	input  wire logic [7:0] pm_addr_i,
	output logic            core_take_o = 1'b0,
	output logic      [7:0] pm_data_o = 8'h5A
);
	always_ff @(posedge clock_i) begin
		// acceptance lags one cycle, like a core finishing an instruction
		core_take_o <= take_en_i;
		if (pm_rd_i) begin
			pm_data_o <= (pm_addr_i < 8'h0C) ? 8'h40 + pm_addr_i : 8'hEE;
		end else begin
			// released bus: never leave the last byte standing
			pm_data_o <= ~pm_data_o;
		end
	end
endmodule : tvi_core_mdl
`default_nettype wire
